// [hw/wdw_pkg.sv]
// Shared constants and types for the watchdog and wake-up block.
// Assumes a single 50 MHz bus clock and a 32-bit APB register port.
package wdw_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_OSC_HZ = 32_000;
  // Bus clocks per slow oscillator cycle, rounded down.
  localparam int unsigned OSC_DIV_CYCLES = CLK_HZ / SLOW_OSC_HZ;
  localparam logic [10:0] OSC_DIV_LAST = 11'(OSC_DIV_CYCLES - 1);

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [11:0] WATCHDOG_CONTROL_OFS = 12'h000;
  localparam logic [11:0] RESET_CAUSE_FLAGS_OFS = 12'h004;
  localparam logic [11:0] PORT_A_WAKE_ENABLE_OFS = 12'h008;
  localparam logic [11:0] PORT_B_WAKE_ENABLE_OFS = 12'h00c;
  localparam logic [11:0] WAKE_STATUS_OFS = 12'h010;

  // Field positions.
  localparam int unsigned WDT_ENABLE_BIT = 3;
  localparam int unsigned PERIOD_SEL_LSB = 0;
  localparam int unsigned LOW_VOLTAGE_RESET_FLAG_BIT = 2;
  localparam int unsigned BAD_VOLTAGE_SETTING_FLAG_BIT = 1;
  localparam int unsigned STAT_PDF_BIT = 0;
  localparam int unsigned STAT_TO_BIT = 1;
  localparam int unsigned STAT_LOW_POWER_BIT = 2;
  localparam int unsigned STAT_COUNT_LSB = 8;

  // Values after reset.
  localparam logic [3:0] WATCHDOG_CONTROL_RESET = 4'hf;
  localparam logic [1:0] RESET_CAUSE_FLAGS_RESET = 2'h0;
  localparam logic [7:0] WAKE_ENABLE_RESET = 8'h00;
  localparam logic [16:0] PIN_IDLE = 17'h1ffff;

  // ****************************************************************
  // Watchdog counting
  // ****************************************************************
  localparam int unsigned PRESCALE_BITS = 7;
  localparam logic [7:0] WDT_TOP = 8'hff;

  // Register select codes.
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_FLAGS = 3'b010,
    SEL_PA = 3'b011,
    SEL_PB = 3'b100,
    SEL_STAT = 3'b101
  } wdw_sel_t;

  // Power state.
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_LOW_POWER = 1'b1
  } wdw_state_t;

  // Wake and reset requests to the core, each a one-cycle pulse except full_reset, which repeats while the reset pin is low.
  typedef struct packed {
    logic full_reset;
    logic pc_sp_reset;
    logic resume_next;
    logic irq_response;
  } wdw_wake_t;

endpackage : wdw_pkg

// [hw/wdw_prescaler.sv]
// Slow oscillator tick generator and free-running watchdog prescaler.
// Assumes pclk at the rate given in the package; no other clock exists.
`timescale 1ns/100ps
module wdw_prescaler
  import wdw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] period_select,
  output logic osc_tick,
  output logic count_tick
);

  // ****************************************************************
  // Slow oscillator emulation
  // ****************************************************************
  logic [10:0] div_cnt;
  logic [10:0] next_div_cnt;
  logic [PRESCALE_BITS-1:0] presc;
  logic [PRESCALE_BITS-1:0] next_presc;
  logic [PRESCALE_BITS-1:0] tap_mask;

  // slow oscillator rate
  // One enable pulse per slow oscillator period.
  always_comb
  begin
    osc_tick = (div_cnt == OSC_DIV_LAST);
    next_div_cnt = osc_tick ? 11'h000 : 11'(div_cnt + 11'h001);
  end

  // free-running prescaler
  // The prescaler is never cleared, which gives the time-out its spread.
  always_comb
  begin
    next_presc = osc_tick ? PRESCALE_BITS'(presc + 1'b1) : presc;
  end

  // select applies immediately
  // Code n passes one tick every 2^n oscillator cycles.
  always_comb
  begin
    tap_mask = PRESCALE_BITS'((8'h01 << period_select) - 8'h01);
    count_tick = osc_tick && ((presc & tap_mask) == tap_mask);
  end

  // Registers of the divider and prescaler.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 11'h000;
      presc <= '0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      presc <= next_presc;
    end
  end

  osc_period_a : assert property (@(posedge pclk) disable iff (!presetn)
    osc_tick |=> !osc_tick) else $error("Oscillator tick lasted more than one cycle.");

endmodule : wdw_prescaler

// [hw/wdw_core.sv]
// Watchdog timer with wake-up control, reached over APB.
// Assumes CPU event inputs are one-cycle pulses on pclk; pins are asynchronous.
//
// Operation
// - Low power ends on pin fall, reset pin, interrupt or watchdog overflow.
// - Stop instruction enters low power and sets the power-down flag.
// - Power-up and clear-watchdog instruction clear the power-down flag.
// - Reset pin wake-up gives a full system reset.
// - Overflow in low power sets time-out, resets only program counter and stack.
// - Each port pin has a wake enable; enabled falling edges wake.
// - Pin wake-up resumes after the stop instruction.
// - Disabled interrupt or full stack resumes after stop; request stays pending.
// - Enabled interrupt with stack room gives the normal interrupt response.
// - Requests already set at entry cannot wake the device.
// - Watchdog counts slow oscillator cycles of about 32 kHz.
// - Period code n times out between 2^(n+8)-2^n and 2^(n+8) cycles.
// - Control bits 7..4 read zero; enable and period reset to one.
// - Overflow while running resets the device and sets time-out.
// - Count cleared by clear instruction, stop instruction, low reset pin.
// - Reset-cause bits 7..3 and 0 read zero; bits 2 and 1 read/write.
// - Entering low power clears the count; it runs only when enabled.
// - Stop instruction clears time-out as it sets power-down.
`timescale 1ns/100ps
module wdw_core
  import wdw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_watchdog_instruction,
  input wire logic stop_instruction,
  input wire logic external_reset_pin_n,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] irq_request,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  output wdw_wake_t wake,
  output logic power_down_flag,
  output logic timeout_flag,
  output logic low_power
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wdw_state_t state;
  wdw_state_t next_state;
  logic [3:0] watchdog_control;
  logic [3:0] next_watchdog_control;
  logic [1:0] reset_cause_flags;
  logic [1:0] next_reset_cause_flags;
  logic [7:0] port_a_wake_enable;
  logic [7:0] next_port_a_wake_enable;
  logic [7:0] port_b_wake_enable;
  logic [7:0] next_port_b_wake_enable;
  logic [7:0] wdt_count;
  logic [7:0] next_wdt_count;
  logic [7:0] irq_at_entry;
  logic [7:0] next_irq_at_entry;
  logic [31:0] next_prdata;
  logic next_power_down_flag;
  logic next_timeout_flag;
  wdw_wake_t next_wake;
  logic [16:0] pin_meta;
  logic [16:0] pin_sync;
  logic [15:0] pin_prev;
  logic osc_tick;
  logic count_tick;
  logic ext_low;
  logic wdt_enable;
  logic clr_any;
  logic overflow;
  logic pin_fall;
  logic [7:0] irq_new;
  logic irq_take;
  logic wr_en;
  wdw_sel_t sel;

  // Maps a byte address onto a register select code.
  function automatic wdw_sel_t addr_map(input logic [11:0] addr);
    case (addr)
      WATCHDOG_CONTROL_OFS: addr_map = SEL_CTRL;
      RESET_CAUSE_FLAGS_OFS: addr_map = SEL_FLAGS;
      PORT_A_WAKE_ENABLE_OFS: addr_map = SEL_PA;
      PORT_B_WAKE_ENABLE_OFS: addr_map = SEL_PB;
      WAKE_STATUS_OFS: addr_map = SEL_STAT;
      default: addr_map = SEL_NONE;
    endcase
  endfunction : addr_map

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Two flops bring reset pin and port pins into the pclk domain.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE[15:0];
    end
    else
    begin
      pin_meta <= {external_reset_pin_n, port_b_pins, port_a_pins};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[15:0];
    end
  end

  // ****************************************************************
  // Watchdog tick source
  // ****************************************************************
  wdw_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .period_select(watchdog_control[PERIOD_SEL_LSB +: 3]),
    .osc_tick(osc_tick),
    .count_tick(count_tick)
  );

  // ****************************************************************
  // Event decode
  // ****************************************************************

  // per-pin falling edges
  // Falling edges are qualified by each pin's own wake enable bit.
  always_comb
  begin
    ext_low = !pin_sync[16];
    pin_fall = |(pin_prev & ~pin_sync[15:0] & {port_b_wake_enable, port_a_wake_enable});
  end

  // requests set before entry
  // Only requests that were clear at entry may wake the device.
  always_comb
  begin
    irq_new = irq_request & ~irq_at_entry;
    irq_take = |(irq_new & irq_enable) && !stack_full;
  end

  // count clear sources
  // Overflow is the count wrapping at top on an enabled counting tick.
  always_comb
  begin
    wdt_enable = watchdog_control[WDT_ENABLE_BIT];
    clr_any = clear_watchdog_instruction || stop_instruction || ext_low;
    overflow = wdt_enable && count_tick && (wdt_count == WDT_TOP) && !clr_any;
  end

  // ****************************************************************
  // Watchdog, flags and power state
  // ****************************************************************

  // Computes the next count, flags, power state and wake pulses.
  always_comb
  begin
    next_state = state;
    next_irq_at_entry = irq_at_entry;
    next_wake = '0;
    next_wdt_count = wdt_count;
    next_power_down_flag = power_down_flag;
    next_timeout_flag = timeout_flag;
    // cleared on entry, runs when enabled
    if (clr_any || overflow)
      next_wdt_count = 8'h00;
    else if (wdt_enable && count_tick)
      next_wdt_count = 8'(wdt_count + 8'h01);
    if (clear_watchdog_instruction)
      next_power_down_flag = 1'b0;
    if (stop_instruction && state == ST_RUN && !ext_low)
      next_timeout_flag = 1'b0;
    // overflow sets time-out, winning over a clear
    if (overflow)
      next_timeout_flag = 1'b1;
    case (state)
      ST_RUN:
      begin
        if (ext_low || overflow)
          next_wake.full_reset = 1'b1;
        else if (stop_instruction)
        begin
          next_state = ST_LOW_POWER;
          next_power_down_flag = 1'b1;
          next_irq_at_entry = irq_request;
        end
      end
      ST_LOW_POWER:
      begin
        if (ext_low)
        begin
          next_wake.full_reset = 1'b1;
          next_state = ST_RUN;
        end
        else if (overflow)
        begin
          // overflow resets counter and stack only
          next_wake.pc_sp_reset = 1'b1;
          next_state = ST_RUN;
        end
        else if (pin_fall)
        begin
          next_wake.resume_next = 1'b1;
          next_state = ST_RUN;
        end
        else if (|irq_new)
        begin
          next_wake.irq_response = irq_take;
          next_wake.resume_next = !irq_take;
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // Registers of the watchdog and power state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_RUN;
      irq_at_entry <= 8'h00;
      wake <= '0;
      wdt_count <= 8'h00;
      power_down_flag <= 1'b0;
      timeout_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      irq_at_entry <= next_irq_at_entry;
      wake <= next_wake;
      wdt_count <= next_wdt_count;
      power_down_flag <= next_power_down_flag;
      timeout_flag <= next_timeout_flag;
    end
  end

  assign low_power = (state == ST_LOW_POWER);

  // ****************************************************************
  // APB register slave
  // ****************************************************************

  // Zero-wait slave; unmapped addresses answer with an error.
  always_comb
  begin
    sel = addr_map(paddr);
    pready = 1'b1;
    pslverr = psel && penable && (sel == SEL_NONE);
    wr_en = psel && penable && pwrite && (sel != SEL_NONE);
  end

  // Computes register writes and the read data for the access phase.
  always_comb
  begin
    next_watchdog_control = watchdog_control;
    next_reset_cause_flags = reset_cause_flags;
    next_port_a_wake_enable = port_a_wake_enable;
    next_port_b_wake_enable = port_b_wake_enable;
    next_prdata = prdata;
    if (wr_en)
    begin
      case (sel)
        // period select writable at any time
        SEL_CTRL: next_watchdog_control = pwdata[3:0];
        SEL_FLAGS: next_reset_cause_flags = pwdata[LOW_VOLTAGE_RESET_FLAG_BIT:BAD_VOLTAGE_SETTING_FLAG_BIT];
        SEL_PA: next_port_a_wake_enable = pwdata[7:0];
        SEL_PB: next_port_b_wake_enable = pwdata[7:0];
        default: next_prdata = prdata;
      endcase
    end
    if (psel && !penable)
    begin
      case (sel)
        SEL_CTRL: next_prdata = {28'h0000000, watchdog_control};
        SEL_FLAGS: next_prdata = {29'h0, reset_cause_flags, 1'b0};
        SEL_PA: next_prdata = {24'h000000, port_a_wake_enable};
        SEL_PB: next_prdata = {24'h000000, port_b_wake_enable};
        SEL_STAT: next_prdata = {16'h0000, wdt_count, 5'h00, low_power, timeout_flag, power_down_flag};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // Registers of the software-visible state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // enable and period reset to one
      watchdog_control <= WATCHDOG_CONTROL_RESET;
      reset_cause_flags <= RESET_CAUSE_FLAGS_RESET;
      port_a_wake_enable <= WAKE_ENABLE_RESET;
      port_b_wake_enable <= WAKE_ENABLE_RESET;
      prdata <= 32'h00000000;
    end
    else
    begin
      watchdog_control <= next_watchdog_control;
      reset_cause_flags <= next_reset_cause_flags;
      port_a_wake_enable <= next_port_a_wake_enable;
      port_b_wake_enable <= next_port_b_wake_enable;
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  stop_entry_a : assert property (stop_instruction && !low_power && !ext_low && !overflow
    |=> low_power && power_down_flag && !timeout_flag) else $error("Stop did not enter low power.");

  pdf_clear_a : assert property (clear_watchdog_instruction && !stop_instruction
    |=> !power_down_flag) else $error("Clear did not drop power-down flag.");

  pin_reset_a : assert property (low_power && ext_low
    |=> wake.full_reset && !low_power) else $error("Reset pin did not give full reset.");

  sleep_tout_a : assert property (low_power && overflow && !ext_low
    |=> wake.pc_sp_reset && timeout_flag && !wake.full_reset) else $error("Sleep time-out wrong.");

  pin_wake_a : assert property (low_power && pin_fall && !ext_low && !overflow
    |=> wake.resume_next && !low_power) else $error("Pin wake did not resume.");

  irq_resp_a : assert property (low_power && !ext_low && !overflow && !pin_fall && |irq_new
    |=> wake.irq_response == $past(irq_take)) else $error("Interrupt wake response wrong.");

  irq_block_a : assert property (low_power && irq_new == 8'h00 && !pin_fall && !overflow && !ext_low
    |=> low_power && wake == '0) else $error("Woke without a source.");

  run_tout_a : assert property (!low_power && overflow && !ext_low
    |=> wake.full_reset && timeout_flag ##1 !wake.full_reset) else $error("Run time-out wrong.");

  count_clear_a : assert property (clr_any |=> wdt_count == 8'h00)
    else $error("Watchdog count not cleared.");

  count_hold_a : assert property (!wdt_enable && !clr_any |=> $stable(wdt_count))
    else $error("Disabled watchdog still counted.");

endmodule : wdw_core

// [test/wdw_core_tb_top.sv]
// Self-checking bench for the watchdog and wake-up block, driving every port itself.
// Assumes the package constants and the APB register map of the block.
`timescale 1ns/100ps
module wdw_core_tb_top
  import wdw_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clear_watchdog_instruction;
  logic stop_instruction;
  logic external_reset_pin_n;
  logic [7:0] port_a_pins;
  logic [7:0] port_b_pins;
  logic [7:0] irq_request;
  logic [7:0] irq_enable;
  logic stack_full;
  wdw_wake_t wake;
  logic power_down_flag;
  logic timeout_flag;
  logic low_power;
  int n_mismatch;
  int compares;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] cnt;
  localparam wdw_wake_t W_NONE = 4'b0000;
  localparam wdw_wake_t W_FULL = 4'b1000;
  localparam wdw_wake_t W_RESUME = 4'b0010;
  localparam wdw_wake_t W_IRQ = 4'b0001;

  wdw_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_watchdog_instruction(clear_watchdog_instruction), .stop_instruction(stop_instruction),
    .external_reset_pin_n(external_reset_pin_n), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
    .irq_request(irq_request), .irq_enable(irq_enable), .stack_full(stack_full), .wake(wake),
    .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .low_power(low_power));

  // ****************************************************************
  // Clock, reset and shared tasks
  // ****************************************************************
  // Free-running 50 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Compares one result word, four-state exact.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A wait that used up its bound ends the run.
  task hang;
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict();
  endtask : hang

  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
      hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write, then register read with a check of data and error.
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, exp_err});
  endtask : rd

  // Reads the watchdog count from the status register.
  task get_count;
    apb(1'b0, WAKE_STATUS_OFS, 32'h0, rdat, rerr);
    cnt = rdat[15:8];
  endtask : get_count

  // One-cycle stop or clear pulse; returns one edge after the pulse is taken.
  task cpu(input logic stop_e);
    @(posedge pclk);
    stop_instruction <= stop_e;
    clear_watchdog_instruction <= !stop_e;
    @(posedge pclk);
    stop_instruction <= 1'b0;
    clear_watchdog_instruction <= 1'b0;
    @(posedge pclk);
  endtask : cpu

  // Waits a bounded time for a wake pulse and checks its kind.
  task wait_wake(input wdw_wake_t exp);
    int i;
    for (i = 0; i < 12; i++)
    begin
      @(posedge pclk);
      if (wake !== W_NONE)
        break;
    end
    chk({28'h0, wake}, {28'h0, exp});
    if (i == 12 && exp !== W_NONE)
      hang();
  endtask : wait_wake

  // Checks power-down flag, time-out flag and low-power state together.
  task chk_flags(input logic [2:0] exp);
    chk({29'h0, low_power, timeout_flag, power_down_flag}, {29'h0, exp});
  endtask : chk_flags

  // Cuts a hung run short.
  initial
  begin
    repeat (100000) @(posedge pclk);
    hang();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    n_mismatch = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clear_watchdog_instruction = 1'b0;
    stop_instruction = 1'b0;
    external_reset_pin_n = 1'b1;
    port_a_pins = 8'hff;
    port_b_pins = 8'hff;
    irq_request = 8'h00;
    irq_enable = 8'h00;
    stack_full = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only zero bits and the unmapped place.
    rd(WATCHDOG_CONTROL_OFS, 32'h0000000f, 1'b0);
    rd(RESET_CAUSE_FLAGS_OFS, 32'h0, 1'b0);
    rd(PORT_A_WAKE_ENABLE_OFS, 32'h0, 1'b0);
    chk_flags(3'b000);
    wr(WATCHDOG_CONTROL_OFS, 32'hfffffff0);
    rd(WATCHDOG_CONTROL_OFS, 32'h0, 1'b0);
    wr(RESET_CAUSE_FLAGS_OFS, 32'hffffffff);
    rd(RESET_CAUSE_FLAGS_OFS, 32'h00000006, 1'b0);
    wr(RESET_CAUSE_FLAGS_OFS, 32'h0);
    rd(RESET_CAUSE_FLAGS_OFS, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    // Counting at period code 0, then code 1, each with a clear instruction between the write and the count.
    wr(WATCHDOG_CONTROL_OFS, 32'h08);
    cpu(1'b0);
    repeat (OSC_DIV_CYCLES * 4 - 30) @(posedge pclk);
    get_count();
    chk({31'h0, cnt == 8'h03 || cnt == 8'h04}, 32'h1);
    wr(WATCHDOG_CONTROL_OFS, 32'h09);
    cpu(1'b0);
    repeat (OSC_DIV_CYCLES * 4 - 30) @(posedge pclk);
    get_count();
    chk({31'h0, cnt == 8'h01 || cnt == 8'h02}, 32'h1);
    // A disabled watchdog holds its count; the clear instruction zeroes it.
    wr(WATCHDOG_CONTROL_OFS, 32'h01);
    get_count();
    repeat (OSC_DIV_CYCLES * 2) @(posedge pclk);
    rd(WAKE_STATUS_OFS, {16'h0, cnt, 8'h00}, 1'b0);
    cpu(1'b0);
    rd(WAKE_STATUS_OFS, 32'h0, 1'b0);
    // Stop, a disabled pin, an enabled pin.
    wr(WATCHDOG_CONTROL_OFS, 32'h08);
    wr(PORT_A_WAKE_ENABLE_OFS, 32'h01);
    rd(PORT_A_WAKE_ENABLE_OFS, 32'h01, 1'b0);
    cpu(1'b1);
    chk_flags(3'b101);
    rd(WAKE_STATUS_OFS, 32'h00000005, 1'b0);
    cpu(1'b1);
    chk_flags(3'b101);
    port_b_pins <= 8'hfe;
    wait_wake(W_NONE);
    port_a_pins <= 8'hfe;
    wait_wake(W_RESUME);
    chk_flags(3'b001);
    port_a_pins <= 8'hff;
    port_b_pins <= 8'hff;
    cpu(1'b0);
    chk_flags(3'b000);
    // Interrupt wakes: pending at entry, enabled, disabled, stack full.
    irq_request <= 8'h02;
    irq_enable <= 8'h06;
    cpu(1'b1);
    wait_wake(W_NONE);
    irq_request <= 8'h06;
    wait_wake(W_IRQ);
    irq_request <= 8'h00;
    cpu(1'b1);
    irq_request <= 8'h08;
    wait_wake(W_RESUME);
    irq_request <= 8'h00;
    stack_full <= 1'b1;
    cpu(1'b1);
    irq_request <= 8'h04;
    wait_wake(W_RESUME);
    chk_flags(3'b001);
    irq_request <= 8'h00;
    stack_full <= 1'b0;
    // Reset pin while asleep gives a full reset and clears the count.
    cpu(1'b1);
    external_reset_pin_n <= 1'b0;
    wait_wake(W_FULL);
    rd(WAKE_STATUS_OFS, 32'h00000001, 1'b0);
    external_reset_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule : wdw_core_tb_top
